// ===== cdc_consts.vh
/*
 * Constants for the comparator and reference DAC control block:
 * register addresses, field positions, reset values and widths.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CDC_CONSTS_VH
`define CDC_CONSTS_VH

// register addresses on the plain register port
`define CDC_ADDR_CONTROL     4'h0
`define CDC_ADDR_DAC_LEVEL   4'h1

// comparator_control field positions
`define CDC_CTL_CHANNEL_ON   15
`define CDC_CTL_SIDL         13
`define CDC_CTL_HYS_HI       12
`define CDC_CTL_HYS_LO       11
`define CDC_CTL_FILTER_EN    10
`define CDC_CTL_FILTER_CLK   9
`define CDC_CTL_REF_OUT_EN   8
`define CDC_CTL_INPUT_SOURCE_FIELD_HI     7
`define CDC_CTL_INPUT_SOURCE_FIELD_LO     6
`define CDC_CTL_EXT_REF      5
`define CDC_CTL_HYS_EDGE     4
`define CDC_CTL_STATUS       3
`define CDC_CTL_ALT_INPUT    2
`define CDC_CTL_INVERT       1
`define CDC_CTL_RANGE        0

// writable bits of comparator_control (bit 14 and status excluded)
`define CDC_CTL_WMASK        16'hBFF7
`define CDC_CTL_RESET        16'h0000
`define CDC_DAC_RESET        12'h000
`define CDC_DAC_WIDTH        12

`endif

// ===== cdc_comparator_dac_control.v
/*
 * Register file and control fan-out for one comparator channel and its
 * reference DAC.
 * Assumes a plain register port (address, write/read strobes, read data
 * one cycle later), an analog comparator output synchronous to clk, and
 * analog muxes/DAC driven from the select outputs below.
 */
// Local design decisions: the register addresses and the plain strobed port.
`include "cdc_consts.vh"

module cdc_comparator_dac_control #(
   parameter ADDR_WIDTH = 4,
   parameter DAC_WIDTH  = 12
) (
   input  wire                  clk,                 // 20 MHz clock
   input  wire                  srst,                // sync reset, high
   input  wire [ADDR_WIDTH-1:0] reg_addr,            // register address
   input  wire [15:0]           reg_wdata,           // write data
   input  wire                  reg_wr,              // write strobe
   input  wire                  reg_rd,              // read strobe
   output reg  [15:0]           reg_rdata,           // read data, next cycle
   input  wire                  comparator_raw,      // analog compare result
   output reg                   channel_on,          // channel enable
   output reg                   stop_in_idle,        // idle stop request
   output reg  [1:0]            hysteresis_level,    // hysteresis amount
   output reg                   filter_enable,       // digital filter on
   output reg                   filter_clock_select, // filter clock choice
   output reg                   reference_output_pin_enable, // to shared pin
   output reg                   external_reference_select,   // dac reference
   output reg                   hysteresis_edge_select,      // 1 = falling
   output reg                   output_invert,       // polarity control
   output reg                   dac_range,           // dac range bit
   output reg  [3:0]            external_input_select, // one-hot pins A..D
   output reg  [1:0]            gain_amp_select,     // one-hot amp 1, 2
   output reg  [DAC_WIDTH-1:0]  reference_code,      // dac code
   output reg                   comparator_out       // polarity-applied output
);

   // ***************************************************************
   // state
   // ***************************************************************
   reg  [1:0] input_source_field;
   reg        alternate_input_select;
   reg        comparator_output_status;
   wire       wr_ctl;
   wire       wr_dac;
   wire       next_cmp;
   wire [15:0] ctl_image;

   assign wr_ctl   = reg_wr && (reg_addr == `CDC_ADDR_CONTROL);
   assign wr_dac   = reg_wr && (reg_addr == `CDC_ADDR_DAC_LEVEL);
   // inversion applied before both status and downstream use
   assign next_cmp = comparator_raw ^ output_invert;

   // ***************************************************************
   // control register
   // ***************************************************************
   always @(posedge clk) begin
      if (srst) begin
         channel_on                  <= 1'b0;
         stop_in_idle                <= 1'b0;
         hysteresis_level            <= 2'h0;
         filter_enable               <= 1'b0;
         filter_clock_select         <= 1'b0;
         reference_output_pin_enable <= 1'b0;
         input_source_field          <= 2'h0;
         external_reference_select   <= 1'b0;
         hysteresis_edge_select      <= 1'b0;
         alternate_input_select      <= 1'b0;
         output_invert               <= 1'b0;
         dac_range                   <= 1'b0;
      end else if (wr_ctl) begin
         // status bit is not among the written fields
         channel_on        <= reg_wdata[`CDC_CTL_CHANNEL_ON];
         stop_in_idle      <= reg_wdata[`CDC_CTL_SIDL];
         hysteresis_level  <= reg_wdata[`CDC_CTL_HYS_HI:`CDC_CTL_HYS_LO];
         filter_enable     <= reg_wdata[`CDC_CTL_FILTER_EN];
         filter_clock_select <= reg_wdata[`CDC_CTL_FILTER_CLK];
         // software keeps this on one comparator at a time
         reference_output_pin_enable <= reg_wdata[`CDC_CTL_REF_OUT_EN];
         input_source_field <=
            reg_wdata[`CDC_CTL_INPUT_SOURCE_FIELD_HI:`CDC_CTL_INPUT_SOURCE_FIELD_LO];
         external_reference_select <= reg_wdata[`CDC_CTL_EXT_REF];
         hysteresis_edge_select <= reg_wdata[`CDC_CTL_HYS_EDGE];
         alternate_input_select <= reg_wdata[`CDC_CTL_ALT_INPUT];
         output_invert     <= reg_wdata[`CDC_CTL_INVERT];
         // stored as written; software is expected to write one
         dac_range         <= reg_wdata[`CDC_CTL_RANGE];
      end
   end

   // ***************************************************************
   // dac level register
   // ***************************************************************
   always @(posedge clk) begin
      if (srst)
         reference_code <= `CDC_DAC_RESET;
      else if (wr_dac)
         reference_code <= reg_wdata[DAC_WIDTH-1:0];
   end

   // ***************************************************************
   // live status and comparator output
   // ***************************************************************
   always @(posedge clk) begin
      if (srst) begin
         comparator_output_status <= 1'b0;
         comparator_out           <= 1'b0;
      end else begin
         // a disabled channel presents a low output
         comparator_output_status <= channel_on & next_cmp;
         comparator_out           <= channel_on & next_cmp;
      end
   end

   // ***************************************************************
   // input source decode
   // ***************************************************************
   always @(posedge clk) begin
      if (srst) begin
         external_input_select <= 4'h0;
         gain_amp_select       <= 2'h0;
      end else if (alternate_input_select) begin
         external_input_select <= 4'h0;
         case (input_source_field)
            2'h0:    gain_amp_select <= 2'h1;
            2'h1:    gain_amp_select <= 2'h2;
            default: gain_amp_select <= 2'h0;  // reserved codes
         endcase
      end else begin
         gain_amp_select       <= 2'h0;
         external_input_select <= 4'h1 << input_source_field;
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   assign ctl_image = {channel_on, 1'b0, stop_in_idle, hysteresis_level,
                       filter_enable, filter_clock_select,
                       reference_output_pin_enable, input_source_field,
                       external_reference_select, hysteresis_edge_select,
                       comparator_output_status, alternate_input_select,
                       output_invert, dac_range};

   always @(posedge clk) begin
      if (srst)
         reg_rdata <= 16'h0000;
      else if (reg_rd) begin
         case (reg_addr)
            `CDC_ADDR_CONTROL:   reg_rdata <= ctl_image;
            `CDC_ADDR_DAC_LEVEL: reg_rdata <=
               {{(16-DAC_WIDTH){1'b0}}, reference_code};
            default:             reg_rdata <= 16'h0000;
         endcase
      end else
         reg_rdata <= 16'h0000;
   end

endmodule

// ===== cdc_monitor.sv
/* Port checker for the comparator control block; bound to its top below. */
module cdc_monitor (
   input wire logic        clk,                   // clock
   input wire logic        srst,                  // sync reset
   input wire logic [3:0]  reg_addr,              // address
   input wire logic [15:0] reg_wdata,             // write data
   input wire logic        reg_wr,                // write strobe
   input wire logic        comparator_raw,        // raw result
   input wire logic        channel_on,            // enable
   input wire logic        output_invert,         // polarity
   input wire logic        comparator_out,        // output
   input wire logic [3:0]  external_input_select, // pin select
   input wire logic [11:0] reference_code);       // dac code
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_ctl_wr; reg_wr && reg_addr == 4'h0; endsequence
   a_chan_on: assert property (s_ctl_wr |=>
      channel_on == $past(reg_wdata[15])) else $error("enable wrong");
   a_chan_hold: assert property (!(reg_wr && reg_addr == 4'h0) |=>
      $stable(channel_on)) else $error("enable moved");
   a_inv_wr: assert property (s_ctl_wr |=>
      output_invert == $past(reg_wdata[1])) else $error("invert wrong");
   a_out_live: assert property (comparator_out == $past(channel_on &
      (comparator_raw ^ output_invert))) else $error("output wrong");
   a_off_zero: assert property (!channel_on |=> !comparator_out)
      else $error("output high while off");
   a_pin_dec: assert property (s_ctl_wr |-> ##2
      external_input_select == ($past(reg_wdata[2], 2) ? 4'h0 :
      4'h1 << $past(reg_wdata[7:6], 2))) else $error("pin select wrong");
   a_dac_wr: assert property (reg_wr && reg_addr == 4'h1 |=>
      reference_code == $past(reg_wdata[11:0])) else $error("dac code wrong");
   a_dac_hold: assert property (!(reg_wr && reg_addr == 4'h1) |=>
      $stable(reference_code)) else $error("dac code moved");
endmodule
bind cdc_comparator_dac_control cdc_monitor u_mon (.*);

// ===== cdc_comparator_dac_control_tb.sv
/* Self-checking bench for the comparator control block; checker is bound. */
module cdc_comparator_dac_control_tb;
timeunit 1ns / 1ns;
logic clk = '0, srst = '1, reg_wr = '0, reg_rd = '0, comparator_raw = '0;
logic [3:0] reg_addr = 4'h0, external_input_select;
logic [15:0] reg_wdata = 16'h0000, reg_rdata;
logic [11:0] reference_code;
logic [1:0] gain_amp_select;
logic external_reference_select, hysteresis_edge_select, comparator_out;
logic channel_on, stop_in_idle, filter_enable, filter_clock_select;
logic reference_output_pin_enable, output_invert, dac_range;
logic [1:0] hysteresis_level;
int err_total = 0, num_checks = 0;
cdc_comparator_dac_control DUT (.*);
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
   num_checks++;
   err_total += int'(got !== exp);
   if (got !== exp) $display("wrong value %0t %h %h", $time, got, exp);
endtask
task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
   @(posedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
   @(posedge clk) {reg_wr, reg_rd} <= 2'h0;
   @(negedge clk);
endtask
task automatic close_out;
   $display("checks %0d errors %0d", num_checks, err_total);
   if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
   else $display("DONE - FAIL");
   $finish;
endtask
task automatic t_regs;
   bus(1'h1, 4'h0, 16'hFFFD);
   chk({external_reference_select, hysteresis_edge_select}, 2'h3);
   chk({channel_on, stop_in_idle, hysteresis_level, filter_enable,
      filter_clock_select, reference_output_pin_enable,
      external_reference_select, hysteresis_edge_select, output_invert,
      dac_range}, 16'h07FD);
   bus(1'h0, 4'h0, 16'h0000);
   chk(reg_rdata, 16'hBFF5);
   bus(1'h1, 4'h1, 16'hFABC);
   bus(1'h0, 4'h1, 16'h0000);
   chk(reg_rdata, 16'h0ABC);
   bus(1'h0, 4'h7, 16'h0000);
   chk(reg_rdata, 16'h0000); // unmapped address reads zero
endtask
task automatic t_rst;
   @(posedge clk) srst <= 1'h1;
   @(posedge clk) srst <= 1'h0;
   bus(1'h0, 4'h0, 16'h0000);
   chk(reg_rdata, 16'h0000);
   bus(1'h0, 4'h1, 16'h0000);
   chk(reg_rdata, 16'h0000);
   chk({channel_on, stop_in_idle, hysteresis_level, filter_enable,
      filter_clock_select, reference_output_pin_enable,
      external_reference_select, hysteresis_edge_select, output_invert,
      dac_range, comparator_out}, 16'h0000);
   chk(reference_code, 16'h0000);
   chk({gain_amp_select, external_input_select}, 16'h0001);
endtask
task automatic t_pol;
   for (int i = 0; i < 8; i++) begin
      @(posedge clk) comparator_raw <= i[0];
      bus(1'h1, 4'h0, {i[2], 13'h0000, i[1], 1'h1});
      @(negedge clk) chk(comparator_out, i[2] & (i[0] ^ i[1]));
   end
endtask
task automatic t_sel;
   for (int i = 0; i < 8; i++) begin
      bus(1'h1, 4'h0, {8'h80, i[1:0], 3'h0, i[2], 2'h1});
      @(negedge clk) chk(gain_amp_select, 2'(i[2] && !i[1]) << i[0]);
      chk(external_input_select, i[2] ? 4'h0 : 4'h1 << i[1:0]);
   end
endtask
initial forever #25 clk = ~clk;
initial begin
   #50000 err_total++;
   close_out();
end
initial begin
   repeat (3) @(posedge clk);
   srst <= 1'h0;
   t_regs();
   t_rst();
   t_pol();
   t_sel();
   close_out();
end
endmodule
